// ===== hdl/vos_regs.sv
// video output and sync control register bank behind the two-wire serial port
module vos_regs
  import vos_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // two-wire serial control
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // monitored sync inputs
  input  wire logic       horizontal_sync_input_a,
  input  wire logic       horizontal_sync_input_b,
  input  wire logic       vertical_sync_input_a,
  input  wire logic       vertical_sync_input_b,
  input  wire logic       green_sync_input_a,
  input  wire logic       green_sync_input_b,
  input  wire logic       pll_hold_input,
  input  wire logic       clamp_input,
  // power-down pin and field status
  input  wire logic       pd_pin,
  input  wire logic       field_odd,
  // clock candidates for the data clock pin
  input  wire logic       pix_clk,
  input  wire logic       pix_clk_90,
  input  wire logic       pix_clk_2x,
  input  wire logic       clk_40m_int,
  // sync candidates
  input  wire logic       raw_sync,
  input  wire logic       filtered_sync,
  input  wire logic       regen_sync,
  // power and output control
  output logic            core_power_down,
  output logic            bandwidth_high,
  output logic [2:0]      out_mode,
  output logic [1:0]      drive_strength,
  output logic            primary_oe,
  output logic            secondary_oe,
  output logic            vertical_sync_output_oe,
  output logic            green_sync_output_oe,
  output logic            data_clock_output_pin,
  output logic            data_clock_oe,
  output logic            field_out,
  // sync routing
  output logic            pll_sync_src,
  output logic            proc_sync_src,
  output logic [7:0]      sync_window_width
);
  logic [7:0]  reg_addr, wr_data, rd_data;
  logic        wr_stb;
  logic [7:0]  pwr, osel1, osel2, rsv_a, rsv_b, win_w;
  logic [7:0]  next_pwr, next_osel1, next_osel2;
  logic [7:0]  next_rsv_a, next_rsv_b, next_win_w;
  logic [7:0]  sync_vec, det_act, det_pol, det_edge;
  logic [7:0]  act_status, pol_status;
  logic [11:0] gap, next_gap, xhold, next_xhold;
  logic        extra, next_extra;
  logic        pd_sel, pd_man, pin_pol, fast_sw, sog_z_pd;
  logic        pri_en, sec_en, clk_inv, all_z, sog_z;
  logic        field_pol, pll_filt, proc_regen;
  logic [2:0]  mode_fld;
  logic [1:0]  drv_fld, clk_sel;
  logic        pin_act, no_act, pd_req, outs_on, clk_mux;
  logic        next_core_pd, next_pri_oe, next_sec_oe, next_vs_oe;
  logic        next_sog_oe, next_dclk, next_dclk_oe, next_field;
  logic        next_pll_src, next_proc_src;
  logic [2:0]  next_mode;
  logic [1:0]  next_drv;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  vos_i2c_slave u_serial (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .scl      (scl),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .reg_addr (reg_addr),
    .wr_stb   (wr_stb),
    .wr_data  (wr_data),
    .rd_data  (rd_data)
  );

  // bit order of the activity status
  assign sync_vec = {horizontal_sync_input_a, horizontal_sync_input_b,
                     vertical_sync_input_a, vertical_sync_input_b,
                     green_sync_input_a, green_sync_input_b,
                     pll_hold_input, clamp_input};

  for (genvar i = 0; i < 8; i++) begin : g_det
    vos_sync_det u_det (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .sync_in   (sync_vec[i]),
      .active    (det_act[i]),
      .pol_high  (det_pol[i]),
      .lead_edge (det_edge[i])
    );
  end

  // live views, no storage behind them
  assign act_status = det_act;
  // green sync has no polarity slot
  assign pol_status = {det_pol[7:4], det_pol[1:0], extra, 1'b0};

  assign pd_sel     = pwr[PWR_PD_SEL];
  assign pd_man     = pwr[PWR_PD];
  assign pin_pol    = pwr[PWR_PIN_POL];
  assign fast_sw    = pwr[PWR_FAST];
  assign sog_z_pd   = pwr[PWR_SOG_Z];
  assign mode_fld   = osel1[O1_MODE_LSB +: 3];
  assign pri_en     = osel1[O1_PRI_EN];
  assign sec_en     = osel1[O1_SEC_EN];
  assign drv_fld    = osel1[O1_DRV_LSB +: 2];
  assign clk_inv    = osel1[O1_CLK_INV];
  assign clk_sel    = osel2[O2_CLK_LSB +: 2];
  assign all_z      = osel2[O2_ALL_Z];
  assign sog_z      = osel2[O2_SOG_Z];
  assign field_pol  = osel2[O2_FIELD_POL];
  assign pll_filt   = osel2[O2_PLL_FILT];
  assign proc_regen = osel2[O2_PROC_REGEN];

  assign bandwidth_high    = pwr[PWR_BW];
  assign sync_window_width = win_w;

  always_comb begin
    next_pwr = pwr;
    next_osel1 = osel1;
    next_osel2 = osel2;
    next_rsv_a = rsv_a;
    next_rsv_b = rsv_b;
    next_win_w = win_w;
    // status offsets decode to nothing here
    if (wr_stb) begin
      if (hit(reg_addr, ADDR_POWER)) next_pwr = wr_data;
      if (hit(reg_addr, ADDR_OSEL1)) next_osel1 = wr_data;
      if (hit(reg_addr, ADDR_OSEL2)) next_osel2 = wr_data;
      if (hit(reg_addr, ADDR_RSV_A)) next_rsv_a = wr_data;
      if (hit(reg_addr, ADDR_RSV_B)) next_rsv_b = wr_data;
      if (hit(reg_addr, ADDR_WINDOW)) next_win_w = wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwr <= RST_POWER;
      osel1 <= RST_OSEL1;
      osel2 <= RST_OSEL2;
      rsv_a <= RST_RSV_A;
      rsv_b <= RST_RSV_B;
      win_w <= RST_WINDOW;
    end else begin
      pwr <= next_pwr;
      osel1 <= next_osel1;
      osel2 <= next_osel2;
      rsv_a <= next_rsv_a;
      rsv_b <= next_rsv_b;
      win_w <= next_win_w;
    end
  end

  always_comb begin
    unique case (reg_addr)
      ADDR_POWER:  rd_data = pwr;
      ADDR_OSEL1:  rd_data = osel1;
      ADDR_OSEL2:  rd_data = osel2;
      ADDR_RSV_A:  rd_data = rsv_a;
      ADDR_RSV_B:  rd_data = rsv_b;
      ADDR_WINDOW: rd_data = win_w;
      ADDR_ACT:    rd_data = act_status;
      ADDR_POL:    rd_data = pol_status;
      default:     rd_data = 8'h00;
    endcase
  end

  // short leading-edge spacing marks equalizing or stray pulses
  always_comb begin
    next_gap = gap;
    next_xhold = xhold;
    if (xhold != 12'h000) next_xhold = xhold - 12'h001;
    if (det_edge[7]) begin
      next_gap = 12'h000;
      if (gap < EXTRA_GAP_CYC) next_xhold = ACT_TIMEOUT_CYC;
    end else if (gap != EXTRA_GAP_CYC) begin
      next_gap = gap + 12'h001;
    end
    next_extra = next_xhold != 12'h000;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gap <= EXTRA_GAP_CYC;
      xhold <= 12'h000;
      extra <= 1'b0;
    end else begin
      gap <= next_gap;
      xhold <= next_xhold;
      extra <= next_extra;
    end
  end

  // the pin request wins in either mode
  assign pin_act = !(pd_pin ^ pin_pol);
  assign no_act  = !(|det_act[7:2]);
  assign pd_req  = pin_act || (pd_sel ? no_act : pd_man);
  assign outs_on = !pd_req && !all_z;

  always_comb begin
    unique case (vos_clksel_t'(clk_sel))
      CLK_PIX:   clk_mux = pix_clk;
      CLK_PIX90: clk_mux = pix_clk_90;
      CLK_PIX2X: clk_mux = pix_clk_2x;
      CLK_INT40: clk_mux = clk_40m_int;
    endcase
  end

  always_comb begin
    // fast switching trades standby power for an instant wake
    next_core_pd = pd_req && !fast_sw;
    next_pri_oe = outs_on && pri_en;
    next_sec_oe = outs_on && sec_en;
    next_vs_oe = outs_on;
    next_dclk_oe = outs_on;
    next_sog_oe = !sog_z && !(pd_req && sog_z_pd);
    next_dclk = clk_mux ^ clk_inv;
    next_field = field_odd ^ field_pol;
    next_pll_src = pll_filt ? filtered_sync : raw_sync;
    next_proc_src = proc_regen ? regen_sync : raw_sync;
    next_mode = mode_fld;
    next_drv = drv_fld;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      core_power_down <= 1'b0;
      primary_oe <= 1'b0;
      secondary_oe <= 1'b0;
      vertical_sync_output_oe <= 1'b0;
      data_clock_oe <= 1'b0;
      green_sync_output_oe <= 1'b0;
      data_clock_output_pin <= 1'b0;
      field_out <= 1'b0;
      pll_sync_src <= 1'b0;
      proc_sync_src <= 1'b0;
      out_mode <= 3'h0;
      drive_strength <= 2'h0;
    end else begin
      core_power_down <= next_core_pd;
      primary_oe <= next_pri_oe;
      secondary_oe <= next_sec_oe;
      vertical_sync_output_oe <= next_vs_oe;
      data_clock_oe <= next_dclk_oe;
      green_sync_output_oe <= next_sog_oe;
      data_clock_output_pin <= next_dclk;
      field_out <= next_field;
      pll_sync_src <= next_pll_src;
      proc_sync_src <= next_proc_src;
      out_mode <= next_mode;
      drive_strength <= next_drv;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  chk_auto_pd: assert property ((pd_sel && no_act && !fast_sw) |=> core_power_down)
    else $error("auto power-down missed with no sync activity");
  chk_manual_pd: assert property ((!pd_sel && !pin_act && !fast_sw)
    |=> (core_power_down == $past(pd_man)))
    else $error("manual power-down bit not followed");
  chk_fast_switch: assert property ((pd_req && fast_sw)
    |=> (!core_power_down && !primary_oe && !vertical_sync_output_oe && !data_clock_oe))
    else $error("fast switching did not keep core up with outputs floating");
  chk_sog_pd: assert property ((pd_req && sog_z_pd) |=> !green_sync_output_oe)
    else $error("green sync output drives during power-down");
  chk_mode_out: assert property ($changed(mode_fld) |=> (out_mode == $past(mode_fld)))
    else $error("output mode not applied");
  chk_primary_oe: assert property ((!pri_en || all_z) |=> !primary_oe)
    else $error("primary port drives while disabled");
  chk_secondary_oe: assert property ((sec_en && outs_on) |=> secondary_oe)
    else $error("secondary port floats while enabled");
  // outputs hold their reset zeros one edge past release
  chk_drive_field: assert property ($past(rstn)
    |-> (drive_strength == $past(drv_fld)))
    else $error("drive strength lags the register");
  chk_clock_invert: assert property ($past(rstn)
    |-> (data_clock_output_pin == ($past(clk_mux) ^ $past(clk_inv))))
    else $error("data clock polarity wrong");
  chk_clock_select: assert property ((clk_sel == 2'h3 && !clk_inv)
    |=> (data_clock_output_pin == $past(clk_40m_int)))
    else $error("internal clock not selected");
  chk_all_hiz: assert property (all_z
    |=> (!primary_oe && !secondary_oe && !vertical_sync_output_oe && !data_clock_oe))
    else $error("an output drives during global high impedance");
  chk_sog_hiz: assert property ((sog_z || (!sog_z && !pd_req))
    |=> (green_sync_output_oe == !$past(sog_z)))
    else $error("green sync high impedance control ignored");
  chk_field_pol: assert property ($past(rstn)
    |-> (field_out == ($past(field_odd) != $past(field_pol))))
    else $error("field output polarity wrong");
  chk_pll_src: assert property (pll_filt |=> (pll_sync_src == $past(filtered_sync)))
    else $error("PLL sync source not filtered");
  chk_proc_src: assert property (!proc_regen |=> (proc_sync_src == $past(raw_sync)))
    else $error("sync processor source not raw");
  chk_extra_flag: assert property ((det_edge[7] && gap < EXTRA_GAP_CYC)
    |=> extra [*8])
    else $error("extraneous pulse flag not raised");
  chk_ro_write: assert property ((wr_stb
    && (reg_addr == ADDR_ACT || reg_addr == ADDR_POL))
    |=> ($stable(pwr) && $stable(osel1) && $stable(osel2) && $stable(win_w)))
    else $error("status write changed a control register");

  cov_osel1_write: cover property (wr_stb && reg_addr == ADDR_OSEL1);
  cov_power_down: cover property ($rose(core_power_down));
  cov_extra_seen: cover property ($rose(extra));
  cov_int_clock: cover property (clk_sel == 2'h3 ##1 $changed(data_clock_output_pin));
endmodule

// ===== hdl/vos_pkg.sv
// shared constants of the video output and sync control register bank
// Behaviour
// - power-down select bit: clear gives manual control, set gives automatic control
// - manual power-down bit: zero runs normally, one powers the device down
// - fast switching keeps the core powered in power-down, only outputs float
// - a power bit floats the green sync output during power-down when set
// - output mode field: 100 is 4:4:4, 101 is 4:2:2, 110 is 4:4:4 DDR
// - primary output enable bit 4: one enables, zero floats; enabled by default
// - secondary output enable bit 3: one enables, zero floats; floats by default
// - two-bit drive strength low to high, all outputs except vertical sync output
// - clock invert bit 0 inverts every clock driven on the data clock pin
// - clock select: pixel, pixel shifted 90 degrees, twice pixel, internal 40 MHz
// - bit 5 floats every output except the green sync output; the field output has no enable here and stays driven
// - bit 4 floats the green sync output alone
// - field polarity bit: zero drives odd field high, one drives even field high
// - PLL sync filter enable picks filtered sync when set, raw sync when clear
// - sync processor input select picks regenerated sync when one, raw when zero
// - sync filter window register in 25 ns steps, default 0x0A
// - activity status reports eight inputs from bit 7 down to bit 0
// - polarity status reports six inputs, one meaning active high
// - polarity status bit 1 reads one when extraneous horizontal sync pulses appear
// - every control register is read and written over the two-wire serial interface; the two status registers are read only
package vos_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int ACT_TIMEOUT_NS = 100000;
  localparam int EXTRA_GAP_NS   = 20000;
  localparam logic [11:0] ACT_TIMEOUT_CYC =
    12'((ACT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] EXTRA_GAP_CYC = 12'(EXTRA_GAP_NS / CLK_PERIOD_NS);
  // arbitrary bus address
  localparam logic [6:0] DEV_ADDR = 7'h4C;
  localparam logic [7:0] ADDR_POWER  = 8'h1E;
  localparam logic [7:0] ADDR_OSEL1  = 8'h1F;
  localparam logic [7:0] ADDR_OSEL2  = 8'h20;
  localparam logic [7:0] ADDR_RSV_A  = 8'h21;
  localparam logic [7:0] ADDR_RSV_B  = 8'h22;
  localparam logic [7:0] ADDR_WINDOW = 8'h23;
  localparam logic [7:0] ADDR_ACT    = 8'h24;
  localparam logic [7:0] ADDR_POL    = 8'h25;
  localparam logic [7:0] RST_POWER  = 8'h20;
  localparam logic [7:0] RST_OSEL1  = 8'h94;
  localparam logic [7:0] RST_OSEL2  = 8'h05;
  localparam logic [7:0] RST_RSV_A  = 8'h20;
  localparam logic [7:0] RST_RSV_B  = 8'h32;
  localparam logic [7:0] RST_WINDOW = 8'h0A;
  localparam int PWR_BW = 5;
  localparam int PWR_PD_SEL = 4;
  localparam int PWR_PD = 3;
  localparam int PWR_PIN_POL = 2;
  localparam int PWR_FAST = 1;
  localparam int PWR_SOG_Z = 0;
  localparam int O1_MODE_LSB = 5;
  localparam int O1_PRI_EN = 4;
  localparam int O1_SEC_EN = 3;
  localparam int O1_DRV_LSB = 1;
  localparam int O1_CLK_INV = 0;
  localparam int O2_CLK_LSB = 6;
  localparam int O2_ALL_Z = 5;
  localparam int O2_SOG_Z = 4;
  localparam int O2_FIELD_POL = 3;
  localparam int O2_PLL_FILT = 2;
  localparam int O2_PROC_REGEN = 1;
  localparam logic [1:0] PH_ADDR = 2'h0;
  localparam logic [1:0] PH_SUB  = 2'h1;
  localparam logic [1:0] PH_DATA = 2'h2;
  typedef enum logic [2:0] {MODE_444 = 3'h4, MODE_422 = 3'h5, MODE_DDR = 3'h6} vos_mode_t;
  typedef enum logic [1:0] {
    CLK_PIX = 2'h0, CLK_PIX90 = 2'h1, CLK_PIX2X = 2'h2, CLK_INT40 = 2'h3
  } vos_clksel_t;
  typedef enum logic [4:0] {
    I2C_IDLE = 5'h01, I2C_RX = 5'h02, I2C_ACK = 5'h04, I2C_TX = 5'h08, I2C_RACK = 5'h10
  } vos_i2c_st_t;
endpackage

// ===== hdl/vos_sync_det.sv
// activity and polarity detector for one sync input
module vos_sync_det
  import vos_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // sync input and results
  input  wire logic sync_in,
  output logic      active,
  output logic      pol_high,
  output logic      lead_edge
);
  logic        prev;
  logic [11:0] idle_cnt, next_idle_cnt;
  logic [9:0]  bal, next_bal;
  logic        next_active, next_pol, next_edge;

  // pulses are the rarer level; pulses wider than ~500 cycles can flip the verdict
  always_comb begin
    next_idle_cnt = idle_cnt;
    next_bal = bal;
    if (sync_in != prev) next_idle_cnt = ACT_TIMEOUT_CYC;
    else if (idle_cnt != 12'h000) next_idle_cnt = idle_cnt - 12'h001;
    if (sync_in && bal != 10'h3FF) next_bal = bal + 10'h001;
    else if (!sync_in && bal != 10'h000) next_bal = bal - 10'h001;
    next_active = next_idle_cnt != 12'h000;
    next_pol = !next_bal[9];
    next_edge = (sync_in != prev) && (sync_in == pol_high);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
      idle_cnt <= 12'h000;
      bal <= 10'h200;
      active <= 1'b0;
      pol_high <= 1'b0;
      lead_edge <= 1'b0;
    end else begin
      prev <= sync_in;
      idle_cnt <= next_idle_cnt;
      bal <= next_bal;
      active <= next_active;
      pol_high <= next_pol;
      lead_edge <= next_edge;
    end
  end
endmodule

// ===== hdl/vos_i2c_slave.sv
// two-wire serial slave with sub-address pointer and auto-increment
module vos_i2c_slave
  import vos_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // serial pins
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // register access
  output logic [7:0]      reg_addr,
  output logic            wr_stb,
  output logic [7:0]      wr_data,
  input  wire logic [7:0] rd_data
);
  vos_i2c_st_t st, next_st;
  logic       scl_d, sda_d, rd_mode, nack, rise, fall;
  logic       next_rd_mode, next_nack, next_oe, next_wr_stb;
  logic [3:0] cnt, next_cnt;
  logic [1:0] phase, next_phase;
  logic [7:0] sh, next_sh, next_ptr, next_wr_data;

  // open drain: only the enable moves
  assign sda_out = 1'b0;
  assign rise = scl && !scl_d;
  assign fall = !scl && scl_d;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_phase = phase;
    next_sh = sh;
    next_rd_mode = rd_mode;
    next_nack = nack;
    next_wr_stb = 1'b0;
    next_wr_data = wr_data;
    next_ptr = reg_addr;
    // pointer moves after the strobe so the write lands at the old address
    if (wr_stb) next_ptr = reg_addr + 8'h01;
    if (scl && scl_d && sda_d && !sda_in) begin
      next_st = I2C_RX;
      next_cnt = 4'h0;
      next_phase = PH_ADDR;
    end else if (scl && scl_d && !sda_d && sda_in) begin
      next_st = I2C_IDLE;
    end else begin
      unique case (st)
        I2C_IDLE: begin
        end
        I2C_RX: begin
          if (rise) begin
            next_sh = {sh[6:0], sda_in};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == 4'h8) begin
            next_cnt = 4'h0;
            next_st = I2C_ACK;
            if (phase == PH_ADDR) begin
              next_rd_mode = sh[0];
              next_phase = PH_SUB;
              if (sh[7:1] != DEV_ADDR) next_st = I2C_IDLE;
            end else if (phase == PH_SUB) begin
              next_ptr = sh;
              next_phase = PH_DATA;
            end else begin
              next_wr_stb = 1'b1;
              next_wr_data = sh;
            end
          end
        end
        I2C_ACK: begin
          if (fall) begin
            next_cnt = 4'h0;
            next_st = rd_mode ? I2C_TX : I2C_RX;
            if (rd_mode) begin
              next_sh = rd_data;
              next_ptr = reg_addr + 8'h01;
            end
          end
        end
        I2C_TX: begin
          if (fall) begin
            next_sh = {sh[6:0], 1'b1};
            next_cnt = cnt + 4'h1;
            if (cnt == 4'h7) next_st = I2C_RACK;
          end
        end
        I2C_RACK: begin
          if (rise) next_nack = sda_in;
          if (fall) begin
            next_st = nack ? I2C_IDLE : I2C_TX;
            next_cnt = 4'h0;
            if (!nack) begin
              next_sh = rd_data;
              next_ptr = reg_addr + 8'h01;
            end
          end
        end
      endcase
    end
    next_oe = (next_st == I2C_ACK) || (next_st == I2C_TX && !next_sh[7]);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= I2C_IDLE;
      {scl_d, sda_d} <= 2'h3;
      cnt <= 4'h0;
      phase <= PH_ADDR;
      sh <= 8'h00;
      {rd_mode, nack, sda_oe, wr_stb} <= 4'h0;
      wr_data <= 8'h00;
      reg_addr <= 8'h00;
    end else begin
      st <= next_st;
      {scl_d, sda_d} <= {scl, sda_in};
      cnt <= next_cnt;
      phase <= next_phase;
      sh <= next_sh;
      {rd_mode, nack, sda_oe, wr_stb} <= {next_rd_mode, next_nack, next_oe, next_wr_stb};
      wr_data <= next_wr_data;
      reg_addr <= next_ptr;
    end
  end

  chk_addr_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st == I2C_RX && fall && cnt == 4'h8 && phase == PH_ADDR && sh[7:1] == DEV_ADDR)
    |=> sda_oe ##1 sda_oe) else $error("address byte not acknowledged");
endmodule

// ===== verification/vos_host.sv
// two-wire serial host model
module vos_host (
  // clock and line levels
  input  wire logic clk_sys,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b1;
  initial scl = 1'b1;
  assign sda = drv & ~sda_oe;  // pulled up once released
  task automatic bit_io(input logic b, output logic q);
    drv = b;
    repeat (4) @(negedge clk_sys);
    scl = 1'b1;
    repeat (2) @(negedge clk_sys);
    q = sda;
    repeat (2) @(negedge clk_sys);
    scl = 1'b0;
  endtask
  // p high: start, low: stop
  task automatic cond(input logic p);
    drv = p;
    repeat (4) @(negedge clk_sys);
    scl = 1'b1;
    repeat (4) @(negedge clk_sys);
    drv = ~p;
    repeat (4) @(negedge clk_sys);
    if (p) scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(m, k);
  endtask
endmodule

// ===== verification/tb.sv
// self-checking bench for the output and sync control registers
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module tb
  import vos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rstn = 1'b0, hs_a = 1'b0, hs_en = 1'b0, pd_pin = 1'b1, field_odd = 1'b0;
  logic raw_sync = 1'b0, filtered_sync = 1'b0, regen_sync = 1'b0;
  logic [6:0] in_v = '0;
  logic [3:0] ck = '0;
  logic scl, sda, sda_oe, core_power_down, bandwidth_high, primary_oe, secondary_oe;
  logic vertical_sync_output_oe, green_sync_output_oe, data_clock_output_pin;
  logic data_clock_oe, field_out, pll_sync_src, proc_sync_src;
  logic [2:0] out_mode;
  logic [1:0] drive_strength;
  logic [7:0] sync_window_width, r, wb [6], rb [6];
  logic [7:0] dflt [6] = '{RST_POWER, RST_OSEL1, RST_OSEL2, RST_RSV_A, RST_RSV_B, RST_WINDOW};
  logic [31:0] rs = 32'd16244;
  int bad_count = 0, cmp_count = 0, hc = 0, hp = 1000;
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) if (hs_en) begin
    hc <= hc + 1;
    hs_a <= (hc % hp) < 50;  // rare high pulses, far apart
  end
  vos_host h (.clk_sys, .sda_oe, .scl, .sda);
  vos_regs uut (.clk_sys, .rstn, .scl, .sda_in(sda), .sda_out(), .sda_oe,
    .horizontal_sync_input_a(hs_a), .horizontal_sync_input_b(in_v[6]),
    .vertical_sync_input_a(in_v[5]), .vertical_sync_input_b(in_v[4]),
    .green_sync_input_a(in_v[3]), .green_sync_input_b(in_v[2]),
    .pll_hold_input(in_v[1]), .clamp_input(in_v[0]), .pd_pin, .field_odd,
    .pix_clk(ck[0]), .pix_clk_90(ck[1]), .pix_clk_2x(ck[2]), .clk_40m_int(ck[3]),
    .raw_sync, .filtered_sync, .regen_sync, .core_power_down, .bandwidth_high,
    .out_mode, .drive_strength, .primary_oe, .secondary_oe, .vertical_sync_output_oe,
    .green_sync_output_oe, .data_clock_output_pin, .data_clock_oe, .field_out,
    .pll_sync_src, .proc_sync_src, .sync_window_width);
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // burst from sub-address a: write wb or read into rb
  task automatic acc(input logic [7:0] a, input int n, input logic rd);
    logic [7:0] q;
    logic k;
    h.cond(1'b1);
    h.xfer({DEV_ADDR, 1'b0}, 1'b1, q, k);
    `CHK(k, 1'b0)
    h.xfer(a, 1'b1, q, k);
    if (rd) begin
      h.cond(1'b1);
      h.xfer({DEV_ADDR, 1'b1}, 1'b1, q, k);
      for (int i = 0; i < n; i++) h.xfer(8'hFF, i == n - 1, rb[i], k);
    end else for (int i = 0; i < n; i++) begin
      h.xfer(wb[i], 1'b1, q, k);
      `CHK(k, 1'b0)
    end
    h.cond(1'b0);
  endtask
  task automatic chk_out(input logic [7:0] p, o1, o2, w);
    logic pd, z;
    logic [3:0] oe;
    pd = p[3] | p[4];  // idle inputs leave auto mode powered down
    z = o2[5] | pd;
    oe = {primary_oe, secondary_oe, vertical_sync_output_oe, data_clock_oe};
    `CHK(core_power_down, pd & ~p[1])
    `CHK({out_mode, drive_strength, bandwidth_high}, {o1[7:5], o1[2:1], p[5]})
    `CHK(sync_window_width, w)
    `CHK(oe, {o1[4] & ~z, o1[3] & ~z, ~z, ~z})
    `CHK(green_sync_output_oe, ~o2[4] & ~(pd & p[0]))
    `CHK(field_out, field_odd ^ o2[3])
    `CHK(pll_sync_src, o2[2] ? filtered_sync : raw_sync)
    `CHK(proc_sync_src, o2[1] ? regen_sync : raw_sync)
    if (!pd) `CHK(data_clock_output_pin, ck[o2[7:6]] ^ o1[0])
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_out(RST_POWER, RST_OSEL1, RST_OSEL2, RST_WINDOW);
    acc(ADDR_POWER, 6, 1'b1);
    for (int i = 0; i < 6; i++) `CHK(rb[i], dflt[i])
    for (int n = 0; n < 8; n++) begin
      r = rnd();
      wb[0] = {2'b00, r[5:3], 1'b0, r[1:0]};  // power pin held inactive
      r = rnd();
      wb[1] = {3'(3'h4 + r[7:5] % 3), r[4:0]};
      r = rnd();
      wb[2] = {r[7:1], 1'b1};
      wb[3] = RST_RSV_A;
      wb[4] = RST_RSV_B;
      wb[5] = rnd();
      {ck, field_odd, raw_sync, filtered_sync, regen_sync} = rnd();
      acc(ADDR_POWER, 6, 1'b0);
      repeat (4) @(negedge clk_sys);
      chk_out(wb[0], wb[1], wb[2], wb[5]);
      acc(ADDR_POWER, 6, 1'b1);
      for (int i = 0; i < 6; i++) `CHK(rb[i], wb[i])
    end
    wb[0] = 8'h30;
    acc(ADDR_POWER, 1, 1'b0);
    hs_en = 1'b1;
    repeat (6000) @(negedge clk_sys);
    `CHK(core_power_down, 1'b0)
    wb[0] = 8'h00;
    acc(ADDR_ACT, 1, 1'b0);
    acc(ADDR_ACT, 2, 1'b1);
    `CHK(rb[0], 8'h80)
    `CHK({rb[1][7], rb[1][1]}, 2'b10)
    hp = 300;  // leading edges now closer than the extraneous gap
    repeat (1000) @(negedge clk_sys);
    acc(ADDR_POL, 1, 1'b1);
    `CHK({rb[0][7], rb[0][1]}, 2'b11)
    acc(8'h30, 1, 1'b1);
    `CHK(rb[0], 8'h00)
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    print_verdict();
  end
endmodule
